/* sqc_pkg.sv */
// Shared constants and carriers for the queued serial command RAM block.
// Assumes a 25 MHz module clock and a separate serial link clock.
package sqc_pkg;

    // Queue geometry
    localparam int QDEPTH      = 16;          // Entries per segment
    localparam int QPTR_W      = 4;           // Queue pointer width
    localparam int WORD_W      = 16;          // Transmit and receive word width
    localparam int LEN_W       = 5;           // Transfer length counter width
    localparam int DLY_W       = 14;          // Delay counter width

    // Host address map, word index, region in bits 5:4
    localparam logic [1:0] REG_RX  = 2'h0;    // Receive segment, read only
    localparam logic [1:0] REG_TX  = 2'h1;    // Transmit segment
    localparam logic [1:0] REG_CMD = 2'h2;    // Command segment, low byte

    // Command byte field positions
    localparam int CMD_HOLD_BIT = 7;          // Hold select after transfer
    localparam int CMD_LSEL_BIT = 6;          // Length select
    localparam int CMD_DAT_BIT  = 5;          // Delay after transfer enable
    localparam int CMD_SELECT_TO_CLOCK_DELAY_ENABLE_BIT = 4;          // Select to clock delay enable

    // Lengths
    localparam logic [LEN_W-1:0] LEN_DEFAULT = 5'h08; // Plain 8-bit transfer
    localparam logic [LEN_W-1:0] LEN_FULL    = 5'h10; // Length field zero means 16

    // Timing
    localparam int MCLK_NS      = 40;         // Module clock period
    localparam int SCK_HALF_NS  = 128;        // Half serial clock, two link clocks
    localparam int HALF_CYC     = (SCK_HALF_NS + MCLK_NS - 1) / MCLK_NS; // Rounded up
    localparam int SELECT_TO_CLOCK_DELAY_ENABLE_UNIT    = 1;          // Module clocks per select delay step
    localparam int DT_UNIT_DEF  = 32;         // Module clocks per post delay step

    // Reset values
    localparam logic [QPTR_W-1:0] PTR_RST = 4'h0; // Completed pointer at reset

    // One command byte
    typedef struct packed {
        logic       hold;      // Keep selects after transfer
        logic       len_sel;   // Use programmed length
        logic       dly_after; // Delay after transfer
        logic       dly_sck;   // Programmed select to clock delay
        logic [3:0] pcs;       // Chip-select pattern
    } sqc_cmd_t;

    // One transfer handed to the link domain
    typedef struct packed {
        logic [WORD_W-1:0] data;  // Right-justified outgoing word
        logic [LEN_W-1:0]  len;   // Bits to shift
    } sqc_xfer_t;

endpackage

/* sqc_queue_ram.sv */
// Queue RAM and per-command sequencer of a queued serial master.
// Assumes a host that holds its request until acknowledged, and a link
// clock that runs free; control inputs are on the module clock.
// Notes on behaviour
// - Receive words right-aligned, LSB at bit 0
// - Unfilled receive bits written as zero
// - Host reads receive segment byte or word
// - Engine never writes transmit segment
// - Commands read only in master mode, never written
// - Sixteen command bytes, pattern plus options
// - Run from new pointer through end pointer
// - Drive assigned select bits as given, unassigned ones at default
// - Default data drives selects when not transferring
// - Assigned output pin drives default immediately
// - Held identical pattern stays steady across transfers
// - Held pattern persists until next pattern applies
// - Length select picks programmed length, else 8
// - Delay after transfer from post delay length
// - Select delay programmed, else half serial clock
// - Entry index pairs command, transmit, receive
// - End match sets finished, stops unless wrapping
// - Completed pointer updates after completion, resets zero
`timescale 1ns/10ps
`default_nettype none

module sqc_queue_ram #(
    parameter int DT_UNIT = sqc_pkg::DT_UNIT_DEF          // Module clocks per post delay step
) (
    input  wire logic                       i_mclk,        // Module clock
    input  wire logic                       i_arst_n,      // Async reset, active low
    input  wire logic                       i_lclk,        // Serial link clock
    // Host RAM port
    input  wire logic                       i_host_req,    // Access request, held until ack
    input  wire logic                       i_host_we,     // Write when high
    input  wire logic [5:0]                 i_host_addr,   // Word index
    input  wire logic [1:0]                 i_host_be,     // Byte enables
    input  wire logic [sqc_pkg::WORD_W-1:0] i_host_wdata,  // Write data
    output logic      [sqc_pkg::WORD_W-1:0] o_host_rdata,  // Read data
    output logic                            o_host_ack,    // Access done, one cycle
    // Control and configuration
    input  wire logic                       i_enable,      // Unit enable
    input  wire logic                       i_master,      // Master mode
    input  wire logic                       i_wraparound_enable, // Restart after end
    input  wire logic [3:0]                 i_new_queue_pointer, // First entry
    input  wire logic [3:0]                 i_end_queue_pointer, // Last entry
    input  wire logic [3:0]                 i_length_field,      // Programmed length, 0 is 16
    input  wire logic [7:0]                 i_post_transfer_delay_length,  // Post delay steps
    input  wire logic [6:0]                 i_select_to_clock_delay_length, // Select delay steps
    input  wire logic [3:0]                 i_default_pin_data,  // Idle select levels
    input  wire logic [3:0]                 i_pin_assignment,    // Pins owned by the unit
    input  wire logic [3:0]                 i_pin_direction,     // Pins set as outputs
    input  wire logic                       i_finished_clr,      // Clear finished flag
    // Status
    output logic [3:0]                      o_completed_entry_pointer, // Last finished entry
    output logic                            o_queue_finished_flag,     // End of queue reached
    output logic                            o_busy,        // Queue running
    // Serial pins
    output logic [3:0]                      o_pcs,         // Peripheral select levels
    output logic [3:0]                      o_pcs_oe,      // Peripheral select enables
    output logic                            o_sck,         // Serial clock
    output logic                            o_mosi,        // Serial data out
    input  wire logic                       i_miso         // Serial data in
);
    import sqc_pkg::*;

    // Sequencer states, Gray along fetch, setup, transfer, store, delay
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_SETUP = 3'b011,
        ST_XFER  = 3'b010,
        ST_STORE = 3'b110,
        ST_DELAY = 3'b111
    } sqc_state_t;

    // Transfer length from a command and the programmed field
    function automatic logic [LEN_W-1:0] xfer_len(input sqc_cmd_t c, input logic [3:0] f);
        if (!c.len_sel)
            return LEN_DEFAULT;
        else if (f == 4'h0)
            return LEN_FULL;
        else
            return {1'b0, f};
    endfunction

    // Host region from the word index
    function automatic logic [1:0] region(input logic [5:0] a);
        return a[5:4];
    endfunction

    // Segments, one entry per queue index
    logic [WORD_W-1:0] rx_mem  [QDEPTH];        // Receive segment
    logic [WORD_W-1:0] tx_mem  [QDEPTH];        // Transmit segment
    logic [7:0]        cmd_mem [QDEPTH];        // Command segment

    sqc_state_t        state_q;                 // Sequencer state
    logic [QPTR_W-1:0] ptr_q;                   // Entry being executed
    sqc_cmd_t          cmd_q;                   // Current command byte
    sqc_xfer_t         xfer_q;                  // Word handed to the link
    logic [DLY_W-1:0]  cnt_q;                   // Delay counter
    logic              stop_q;                  // Queue ended, await disable
    logic              active_q;                // Pattern owns the selects
    logic              start_tog_q;             // Start event toggle
    logic [2:0]        done_sync_q;             // Done toggle synchroniser
    logic              done_evt;                // Link finished a word
    logic              eng_ram;                 // Engine uses RAM this cycle
    logic              host_go;                 // Host access proceeds
    logic [3:0]        hidx;                    // Host entry index
    logic [QPTR_W-1:0] ptr_next;                // Next entry
    // Link domain state, declared here because the module clock side reads it
    logic [2:0]        l_start_sync_q;          // Start toggle synchroniser
    logic [1:0]        l_miso_q;                // Input pin synchroniser
    logic              l_busy_q;                // Shifting
    logic [1:0]        l_phase_q;               // Quarter of a bit time
    logic [LEN_W-1:0]  l_cnt_q;                 // Bits remaining
    logic [WORD_W-1:0] l_rx_q;                  // Received word, read after done
    logic              l_done_tog_q;            // Done event toggle
    logic              l_start_evt;             // New request seen

    assign eng_ram  = (state_q == ST_FETCH) || (state_q == ST_STORE);
    // Engine wins every shared cycle; the host just sees a later ack
    assign host_go  = i_host_req && !o_host_ack && !eng_ram;
    assign hidx     = i_host_addr[3:0];
    assign done_evt = done_sync_q[1] ^ done_sync_q[2];
    // Wrap restarts from the new pointer rather than entry zero
    assign ptr_next = (ptr_q == i_end_queue_pointer) ? i_new_queue_pointer : ptr_q + 4'h1;

    // Host writes; receive segment is not host writable
    always_ff @(posedge i_mclk)
    begin
        if (host_go && i_host_we && region(i_host_addr) == REG_TX)
        begin
            if (i_host_be[0])
                tx_mem[hidx][7:0] <= i_host_wdata[7:0];
            if (i_host_be[1])
                tx_mem[hidx][15:8] <= i_host_wdata[15:8];
        end
        if (host_go && i_host_we && region(i_host_addr) == REG_CMD && i_host_be[0])
            cmd_mem[hidx] <= i_host_wdata[7:0];
    end

    // Receive store by the engine only, the full word so upper bits clear
    always_ff @(posedge i_mclk)
    begin
        if (state_q == ST_STORE)
            rx_mem[ptr_q] <= l_rx_q;
    end

    // Host read data and ack; byte lanes come from the same word
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_host_rdata <= 16'h0000;
            o_host_ack   <= 1'b0;
        end
        else
        begin
            o_host_ack <= host_go;
            if (host_go && !i_host_we)
            begin
                case (region(i_host_addr))
                    REG_RX:  o_host_rdata <= rx_mem[hidx];
                    REG_TX:  o_host_rdata <= tx_mem[hidx];
                    REG_CMD: o_host_rdata <= {8'h00, cmd_mem[hidx]};
                    default: o_host_rdata <= 16'h0000;                 // Unmapped reads zero
                endcase
            end
        end
    end

    // Queue sequencer
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_q     <= ST_IDLE;
            ptr_q       <= PTR_RST;
            cmd_q       <= '0;
            xfer_q      <= '0;
            cnt_q       <= '0;
            stop_q      <= 1'b0;
            start_tog_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (!i_enable)
                        stop_q <= 1'b0;
                    else if (i_master && !stop_q)
                    begin
                        ptr_q   <= i_new_queue_pointer;
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    // Command read only on the master path; segment never written here
                    cmd_q       <= sqc_cmd_t'(cmd_mem[ptr_q]);
                    xfer_q.data <= tx_mem[ptr_q];
                    xfer_q.len  <= xfer_len(sqc_cmd_t'(cmd_mem[ptr_q]), i_length_field);
                    if (cmd_mem[ptr_q][CMD_SELECT_TO_CLOCK_DELAY_ENABLE_BIT])
                        cnt_q <= DLY_W'(i_select_to_clock_delay_length) * DLY_W'(SELECT_TO_CLOCK_DELAY_ENABLE_UNIT);
                    else
                        cnt_q <= DLY_W'(HALF_CYC);
                    state_q <= ST_SETUP;
                end
                ST_SETUP:
                begin
                    // Selects turn valid after the first setup cycle; wait before the first clock edge
                    if (cnt_q <= DLY_W'(1))
                    begin
                        start_tog_q <= ~start_tog_q;
                        state_q     <= ST_XFER;
                    end
                    else
                        cnt_q <= cnt_q - DLY_W'(1);
                end
                ST_XFER:
                begin
                    if (done_evt)
                        state_q <= ST_STORE;
                end
                ST_STORE:
                begin
                    if (cmd_q.dly_after && i_post_transfer_delay_length != 8'h00)
                    begin
                        cnt_q   <= DLY_W'(i_post_transfer_delay_length) * DLY_W'(DT_UNIT);
                        state_q <= ST_DELAY;
                    end
                    else
                        cnt_q <= DLY_W'(1);
                    if (!(cmd_q.dly_after && i_post_transfer_delay_length != 8'h00))
                        state_q <= ST_DELAY;
                end
                ST_DELAY:
                begin
                    if (cnt_q <= DLY_W'(1))
                    begin
                        // End match stops the queue unless wrapping
                        if (!i_enable || !i_master ||
                            (o_completed_entry_pointer == i_end_queue_pointer && !i_wraparound_enable))
                        begin
                            stop_q  <= i_enable;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            ptr_q   <= ptr_next;
                            state_q <= ST_FETCH;
                        end
                    end
                    else
                        cnt_q <= cnt_q - DLY_W'(1);
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Completed pointer and finished flag; a set beats a same-cycle clear
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_completed_entry_pointer <= PTR_RST;
            o_queue_finished_flag     <= 1'b0;
        end
        else
        begin
            if (state_q == ST_STORE)
                o_completed_entry_pointer <= ptr_q;
            if (state_q == ST_STORE && ptr_q == i_end_queue_pointer)
                o_queue_finished_flag <= 1'b1;
            else if (i_finished_clr)
                o_queue_finished_flag <= 1'b0;
        end
    end

    // Select ownership: pattern from fetch on, kept after store only if held
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            active_q <= 1'b0;
        else if (!i_enable || !i_master)
            active_q <= 1'b0;
        else if (state_q == ST_FETCH)
            active_q <= 1'b1;
        else if (state_q == ST_STORE)
            active_q <= cmd_q.hold;
    end

    // Select pins per bit; a held pattern switches straight to the next one
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pcs    <= 4'h0;
            o_pcs_oe <= 4'h0;
            o_busy   <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (i_enable && i_pin_assignment[i] && active_q)
                    o_pcs[i] <= cmd_q.pcs[i];
                else
                    o_pcs[i] <= i_default_pin_data[i];
            end
            o_pcs_oe <= i_pin_direction;
            o_busy   <= (state_q != ST_IDLE);
        end
    end

    // Done toggle from the link crosses on three flops; edge on the last two
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            done_sync_q <= 3'h0;
        else
            done_sync_q <= {done_sync_q[1:0], l_done_tog_q};
    end

    // Link domain: the request word is stable from toggle to done
    assign l_start_evt = l_start_sync_q[1] ^ l_start_sync_q[2];

    // Start toggle and input pin synchronisers
    always_ff @(posedge i_lclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            l_start_sync_q <= 3'h0;
            l_miso_q       <= 2'h0;
        end
        else
        begin
            l_start_sync_q <= {l_start_sync_q[1:0], start_tog_q};
            l_miso_q       <= {l_miso_q[0], i_miso};
        end
    end

    // Shifter: MSB first, four link clocks per bit, sample at the falling edge
    always_ff @(posedge i_lclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            l_busy_q     <= 1'b0;
            l_phase_q    <= 2'h0;
            l_cnt_q      <= '0;
            l_rx_q       <= 16'h0000;
            l_done_tog_q <= 1'b0;
            o_sck        <= 1'b0;
            o_mosi       <= 1'b0;
        end
        else if (!l_busy_q)
        begin
            if (l_start_evt)
            begin
                l_busy_q  <= 1'b1;
                l_phase_q <= 2'h0;
                l_cnt_q   <= xfer_q.len;
                l_rx_q    <= 16'h0000;
            end
        end
        else
        begin
            l_phase_q <= l_phase_q + 2'h1;
            case (l_phase_q)
                2'h0: o_mosi <= xfer_q.data[4'(l_cnt_q - LEN_W'(1))];
                2'h1: o_sck  <= 1'b1;
                2'h3:
                begin
                    o_sck   <= 1'b0;
                    // Shift in at bit 0 so the word lands right-aligned
                    l_rx_q  <= {l_rx_q[WORD_W-2:0], l_miso_q[1]};
                    l_cnt_q <= l_cnt_q - LEN_W'(1);
                    if (l_cnt_q == LEN_W'(1))
                    begin
                        l_busy_q     <= 1'b0;
                        l_done_tog_q <= ~l_done_tog_q;
                    end
                end
                default: ;
            endcase
        end
    end

endmodule

`default_nettype wire

/* sqc_queue_ram_assertions.sv */
// Concurrent checks on the queue RAM ports, bound into every instance.
// Assumes the asynchronous active-low reset covers both clock domains.
`timescale 1ns/10ps
`default_nettype none
module sqc_queue_ram_chk (
    input wire logic       i_mclk, i_arst_n, i_lclk, i_host_req, o_host_ack, i_enable, i_finished_clr,
    input wire logic [3:0] i_end_queue_pointer, i_default_pin_data, i_pin_assignment, i_pin_direction,
    input wire logic [3:0] o_completed_entry_pointer, o_pcs, o_pcs_oe,
    input wire logic       o_queue_finished_flag, o_busy, o_sck
);
    // A new host request, then its answer one to four cycles later
    sequence s_ask;
        $rose(i_host_req);
    endsequence
    sequence s_answer;
        ##[1:4] o_host_ack;
    endsequence
    a_host_answer: assert property (@(posedge i_mclk) disable iff (!i_arst_n) s_ask |-> s_answer)
        else $error("host request not answered in time");
    a_pin_enable: assert property (@(posedge i_mclk) disable iff (!i_arst_n) 1 |=> o_pcs_oe == $past(i_pin_direction))
        else $error("select enables do not follow direction");
    // Past reset guards against sampling the cleared outputs at the first edge
    a_spare_pins: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        $past(i_arst_n) && $stable(i_default_pin_data) && $stable(i_pin_assignment)
        |-> ((o_pcs ^ i_default_pin_data) & ~i_pin_assignment) == 4'h0)
        else $error("unassigned select pin not at default level");
    a_idle_default: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        $past(i_arst_n) && !i_enable && $past(!i_enable) && $stable(i_default_pin_data)
        |-> o_pcs == i_default_pin_data)
        else $error("disabled unit not driving default selects");
    a_done_moves: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        $changed(o_completed_entry_pointer) |-> $past(o_busy))
        else $error("completed pointer moved while idle");
    a_end_match: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        $rose(o_queue_finished_flag) |-> o_completed_entry_pointer == i_end_queue_pointer)
        else $error("finished flag set away from end pointer");
    a_flag_sticky: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        o_queue_finished_flag && !i_finished_clr |=> o_queue_finished_flag)
        else $error("finished flag dropped without clear");
    a_sck_idle: assert property (@(posedge i_lclk) disable iff (!i_arst_n) !o_busy [*8] |-> !o_sck)
        else $error("serial clock active outside a queue");
endmodule
bind sqc_queue_ram sqc_queue_ram_chk chk (.i_mclk, .i_arst_n, .i_lclk, .i_host_req, .o_host_ack, .i_enable,
    .i_finished_clr, .i_end_queue_pointer, .i_default_pin_data, .i_pin_assignment, .i_pin_direction,
    .o_completed_entry_pointer, .o_pcs, .o_pcs_oe, .o_queue_finished_flag, .o_busy, .o_sck);
`default_nettype wire

/* sqc_peer.sv */
// Far-side serial peripheral: a mode 0 slave that answers ones while selected.
// Assumes it is selected while select bit 0 is high.
`timescale 1ns/10ps
`default_nettype none
module sqc_peer (
    input  wire logic   i_sck,  // Serial clock
    input  wire logic   i_sel,  // Select, active high
    input  wire logic   i_mosi, // Data from master
    output logic        o_miso, // Data to master
    output logic [15:0] o_seen  // Bits taken in, newest at bit 0
);
    // Line follows the select: ones while selected, zero once released
    assign o_miso = i_sel;
    // Master data is steady across the rising clock in mode 0
    always_ff @(posedge i_sck)
    begin
        if (i_sel)
            o_seen <= {o_seen[14:0], i_mosi};
    end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench: host accesses, a row table of single commands, hand tests.
// Assumes sqc_peer on the serial side and a free-running link clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sqc_pkg::*;
    typedef struct packed {logic [7:0] cmd; logic [3:0] lf; logic [15:0] rx, mo;} sqc_row_t;
    logic        mclk = 0, lclk = 0, rst_n = 0, req = 0, we = 0, en = 0, wrap = 0, fclr = 0, mst = 1;
    logic        ack, fin, busy, sck, mosi, miso;
    logic [1:0]  be = 2'h3;
    logic [5:0]  addr = 6'h00;
    logic [15:0] wd = 16'h0000, rd, cap;
    logic [3:0]  newp = 4'h0, endp = 4'h0, lenf = 4'h0, asg = 4'hB, cptr, pcs, oe;
    int          miscompares = 0, checks_done = 0, cycles = 0, drops = 0;
    // Command, length field, receive word, bits seen by the peer
    sqc_row_t    rows [4] = '{'{8'h05, 4'h0, 16'h00FF, 16'h00C3}, '{8'h45, 4'hC, 16'h0FFF, 16'h05C3},
                              '{8'h45, 4'h0, 16'hFFFF, 16'hA5C3}, '{8'h75, 4'h9, 16'h01FF, 16'h01C3}};
    always #20 mclk = ~mclk;
    initial #7 forever #32 lclk = ~lclk;
    // Deselects seen on select 0, to tell held patterns from dropped ones
    always @(negedge pcs[0]) drops++;
    sqc_queue_ram #(.DT_UNIT(1)) dut (
        .i_mclk(mclk), .i_arst_n(rst_n), .i_lclk(lclk), .i_host_req(req), .i_host_we(we),
        .i_host_addr(addr), .i_host_be(be), .i_host_wdata(wd), .o_host_rdata(rd), .o_host_ack(ack),
        .i_enable(en), .i_master(mst), .i_wraparound_enable(wrap), .i_new_queue_pointer(newp),
        .i_end_queue_pointer(endp), .i_length_field(lenf), .i_post_transfer_delay_length(8'h02),
        .i_select_to_clock_delay_length(7'h03), .i_default_pin_data(4'hA), .i_pin_assignment(asg),
        .i_pin_direction(4'hF), .i_finished_clr(fclr), .o_completed_entry_pointer(cptr),
        .o_queue_finished_flag(fin), .o_busy(busy), .o_pcs(pcs), .o_pcs_oe(oe), .o_sck(sck),
        .o_mosi(mosi), .i_miso(miso));
    sqc_peer peer (.i_sck(sck), .i_sel(pcs[0]), .i_mosi(mosi), .o_miso(miso), .o_seen(cap));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        checks_done++;
        if (a !== e)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    // Host access held until the acknowledge is seen, then released
    task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(negedge mclk);
        req = 1;
        we = w;
        addr = a;
        wd = d;
        repeat (8)
        begin
            @(negedge mclk);
            if (ack === 1'b1)
                break;
        end
        chk({15'h0000, ack}, 16'h0001);
        req = 0;
    endtask
    task automatic wait_fin();
        repeat (4000)
        begin
            @(negedge mclk);
            if (fin === 1'b1)
                break;
        end
        chk({15'h0000, fin}, 16'h0001);
    endtask
    task automatic pulse_clr();
        fclr = 1;
        @(negedge mclk);
        fclr = 0;
    endtask
    // Run a queue to its end, then disable and clear the flag
    task automatic run(input logic [3:0] n, input logic [3:0] e);
        newp = n;
        endp = e;
        en = 1;
        wait_fin();
        chk({12'h000, cptr}, {12'h000, e});
        if (wrap)
        begin
            pulse_clr();
            wait_fin();
            chk({15'h0000, fin}, 16'h0001);
        end
        en = 0;
        pulse_clr();
        for (int n = 0; n < 80 && busy !== 1'b0; n++) @(negedge mclk);
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        int d0;
        repeat (5) @(negedge mclk);
        rst_n = 1;
        @(negedge mclk);
        chk({3'h0, fin, cptr, pcs, oe}, 16'h00AF);
        $display("test reset done");
        foreach (rows[i])
        begin
            lenf = rows[i].lf;
            acc(1, 6'h10, 16'hA5C3);
            acc(1, 6'h20, {8'h00, rows[i].cmd});
            run(4'h0, 4'h0);
            acc(0, 6'h00, 16'h0000);
            chk(rd, rows[i].rx);
            chk(cap & rows[i].rx, rows[i].mo);
            acc(0, 6'h10, 16'h0000);
            chk(rd, 16'hA5C3);
            acc(0, 6'h20, 16'h0000);
            chk(rd & 16'h00FF, {8'h00, rows[i].cmd});
            $display("test row %0d done", i);
        end
        acc(1, 6'h11, 16'h1234);
        be = 2'h1;
        acc(1, 6'h11, 16'hABCD);
        be = 2'h3;
        acc(1, 6'h00, 16'h5555);
        acc(0, 6'h11, 16'h0000);
        chk(rd, 16'h12CD);
        acc(0, 6'h00, 16'h0000);
        chk(rd, 16'h01FF);
        acc(0, 6'h3F, 16'h0000);
        chk(rd, 16'h0000);
        $display("test host map done");
        for (int k = 2; k < 5; k++)
            acc(1, {2'h2, k[3:0]}, 16'h0085);
        d0 = drops;
        run(4'h2, 4'h4);
        chk(16'(drops - d0), 16'h0001);
        for (int k = 2; k < 5; k++)
        begin
            acc(0, {2'h0, k[3:0]}, 16'h0000);
            chk(rd, 16'h00FF);
        end
        wrap = 1;
        run(4'h3, 4'h3);
        wrap = 0;
        mst = 0;
        en = 1;
        repeat (20) @(negedge mclk);
        chk({15'h0000, busy}, 16'h0000);
        en = 0;
        mst = 1;
        $display("test queue done");
        en = 1;
        repeat (30) @(negedge mclk);
        rst_n = 0;
        en = 0;
        @(negedge mclk);
        chk({3'h0, fin, cptr, pcs, oe}, 16'h0000);
        rst_n = 1;
        repeat (2) @(negedge mclk);
        chk({3'h0, fin, cptr, pcs, oe}, 16'h00AF);
        $display("test second reset done");
        summarize();
    end
endmodule
`default_nettype wire
